/* File: qows_pkg.sv */
//----------------------------------------------------------------------
// Notes on behaviour
//----------------------------------------------------------------------
// Notes on behaviour
// - one ordering bit per receive queue
// - bit clear lets messages arrive out of order
// - bit set keeps source transmit order
// - ordering bits read/write, reset zero, upper reserved
// - transmit queue chosen by weighted round-robin slots
// - four byte slots per word, pointer low nibble
// - slot k resets to queue k, count zero
// - count sets messages per slot per pass
// - advance slot after count, fifteen wraps zero
package qows_pkg;

    //------------------------------------------------------------------
    // register map
    //------------------------------------------------------------------
    localparam logic [11:0] RX_ORDER_OFF     = 12'h744;
    localparam logic [11:0] SLOTS_0_3_OFF    = 12'h7E0;
    localparam logic [11:0] SLOTS_4_7_OFF    = 12'h7E4;
    localparam logic [11:0] SLOTS_8_11_OFF   = 12'h7E8;
    localparam logic [11:0] SLOTS_12_15_OFF  = 12'h7EC;
    localparam logic [11:0] WRR_STATUS_OFF   = 12'h7F0;

    //------------------------------------------------------------------
    // fields and reset values
    //------------------------------------------------------------------
    localparam int          NUM_Q            = 16;
    localparam int          PTR_LSB          = 0;
    localparam int          CNT_LSB          = 4;
    localparam int          FIELD_W          = 4;
    localparam logic [15:0] RX_ORDER_RESET   = 16'h0000;
    localparam logic [127:0] SLOT_RESET      =
        128'h0F0E0D0C0B0A09080706050403020100;

    //------------------------------------------------------------------
    // types
    //------------------------------------------------------------------
    typedef enum logic [1:0] {
        WRR_LOOK  = 2'h0,
        WRR_CHECK = 2'h1,
        WRR_SERVE = 2'h3
    } qows_wrr_state_t;

    typedef struct packed {
        logic       valid;
        logic [3:0] queue;
    } qows_tx_sel_t;

    typedef struct packed {
        logic       valid;
        logic [3:0] queue;
        logic       in_seq;
    } qows_rx_msg_t;

    typedef struct packed {
        logic       accept;
        logic       defer;
        logic [3:0] queue;
    } qows_rx_verdict_t;

endpackage

/* File: qows_rx_order.sv */
`timescale 1ns/10ps
module qows_rx_order (
    input  wire logic                      clk,      // pclk
    input  wire logic                      rst_n,    // async reset, low
    input  wire logic [15:0]               in_order, // per-queue ordering
    input  wire qows_pkg::qows_rx_msg_t    msg,      // arriving message
    output      qows_pkg::qows_rx_verdict_t verdict  // accept or defer
);
    logic [15:0] allow;

    for (genvar n = 0; n < qows_pkg::NUM_Q; n++) begin : g_q
        assign allow[n] = ~in_order[n] | msg.in_seq;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            verdict <= '0;
        end else begin
            verdict.accept <= msg.valid & allow[msg.queue];
            verdict.defer  <= msg.valid & ~allow[msg.queue];
            verdict.queue  <= msg.queue;
        end
    end

    property p_free_order;
        @(posedge clk) disable iff (!rst_n)
        (msg.valid && !in_order[msg.queue]) |=>
            verdict.accept && !verdict.defer;
    endproperty
    a_free_order: assert property (p_free_order)
        else $error("unordered queue refused a message");

    property p_strict_order;
        @(posedge clk) disable iff (!rst_n)
        (msg.valid && in_order[msg.queue] && !msg.in_seq) |=>
            verdict.defer && !verdict.accept;
    endproperty
    a_strict_order: assert property (p_strict_order)
        else $error("ordered queue took message out of sequence");

    c_defer: cover property (@(posedge clk) disable iff (!rst_n)
        verdict.defer);
endmodule

/* File: qows_slot_file.sv */
`timescale 1ns/10ps
module qows_slot_file (
    input  wire logic        clk,     // pclk
    input  wire logic        rst_n,   // async reset, low
    input  wire logic        wen,     // word write
    input  wire logic [1:0]  widx,    // word index
    input  wire logic [31:0] wdata,   // word data
    input  wire logic [1:0]  ridx,    // bus read index
    output      logic [31:0] rdata,   // bus read word
    input  wire logic [3:0]  sidx,    // scheduler slot
    output      logic [7:0]  sdata    // scheduler slot byte
);
    logic [127:0] slots;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slots <= qows_pkg::SLOT_RESET;
        end else if (wen) begin
            slots[{widx, 5'h00} +: 32] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 32'h00000000;
            sdata <= 8'h00;
        end else begin
            rdata <= slots[{ridx, 5'h00} +: 32];
            sdata <= slots[{sidx, 3'h0} +: 8];
        end
    end

    property p_slot_reset;
        @(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> slots == qows_pkg::SLOT_RESET;
    endproperty
    a_slot_reset: assert property (p_slot_reset)
        else $error("slot map not at reset value");

    property p_slot_byte;
        @(posedge clk) disable iff (!rst_n)
        (wen && widx == 2'h1) ##1 (sidx == 4'h5) |=>
            sdata == $past(wdata[15:8], 2);
    endproperty
    a_slot_byte: assert property (p_slot_byte)
        else $error("slot byte lane mismatch");
endmodule

/* File: qows_top.sv */
`timescale 1ns/10ps
module qows_top (
    input  wire logic                       pclk,      // bus clock
    input  wire logic                       presetn,   // async reset, low
    input  wire logic                       psel,      // apb select
    input  wire logic                       penable,   // apb enable
    input  wire logic                       pwrite,    // apb direction
    input  wire logic [11:0]                paddr,     // apb byte address
    input  wire logic [31:0]                pwdata,    // apb write data
    output      logic [31:0]                prdata,    // apb read data
    output      logic                       pready,    // apb ready
    output      logic                       pslverr,   // apb error
    input  wire logic [15:0]                tx_queue_pending, // queue has work
    input  wire logic                       tx_msg_done,  // one msg sent
    output      qows_pkg::qows_tx_sel_t     tx_sel,       // queue to serve
    input  wire qows_pkg::qows_rx_msg_t     rx_msg,       // arriving msg
    output      qows_pkg::qows_rx_verdict_t rx_verdict,   // accept/defer
    output      logic [15:0]                rx_in_order   // ordering bits
);
    //------------------------------------------------------------------
    // register decode
    //------------------------------------------------------------------
    logic        hit_order;
    logic        hit_slot;
    logic        hit_status;
    logic        hit_any;
    logic        access;
    logic        wr_fire;
    logic [15:0] rx_order;
    logic [31:0] slot_rdata;
    logic [7:0]  slot_byte;
    logic [31:0] status_word;

    qows_pkg::qows_wrr_state_t state;
    logic [3:0]  cur_slot;
    logic [3:0]  served;
    logic [3:0]  cnt_l;
    logic [15:0] pend_q;

    assign hit_order  = paddr == qows_pkg::RX_ORDER_OFF;
    assign hit_slot   = (paddr[11:4] == qows_pkg::SLOTS_0_3_OFF[11:4])
                        && (paddr[1:0] == 2'h0);
    assign hit_status = paddr == qows_pkg::WRR_STATUS_OFF;
    assign hit_any    = hit_order | hit_slot | hit_status;
    // one wait state: slot read data is registered in the slot file
    assign access     = psel & penable & ~pready;
    assign wr_fire    = psel & penable & pready & pwrite;
    assign status_word = {16'h0000, served, cur_slot,
                          6'h00, state};

    //------------------------------------------------------------------
    // apb answer
    //------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= access;
            pslverr <= access & ~hit_any;
            prdata  <= 32'h00000000;
            if (access && !pwrite) begin
                if (hit_order) begin
                    prdata <= {16'h0000, rx_order};
                end else if (hit_slot) begin
                    prdata <= slot_rdata;
                end else if (hit_status) begin
                    prdata <= status_word;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_order <= qows_pkg::RX_ORDER_RESET;
        end else if (wr_fire && hit_order) begin
            rx_order <= pwdata[15:0];
        end
    end

    assign rx_in_order = rx_order;

    //------------------------------------------------------------------
    // slot storage and receive ordering
    //------------------------------------------------------------------
    qows_slot_file u_slots (
        .clk   (pclk),
        .rst_n (presetn),
        .wen   (wr_fire & hit_slot),
        .widx  (paddr[3:2]),
        .wdata (pwdata),
        .ridx  (paddr[3:2]),
        .rdata (slot_rdata),
        .sidx  (cur_slot),
        .sdata (slot_byte)
    );

    qows_rx_order u_rx (
        .clk      (pclk),
        .rst_n    (presetn),
        .in_order (rx_order),
        .msg      (rx_msg),
        .verdict  (rx_verdict)
    );

    //------------------------------------------------------------------
    // weighted round-robin scheduler
    //------------------------------------------------------------------
    // count is latched on entry, so a slot rewrite mid-service only takes
    // effect on the next pass; zero-count or idle slots are skipped
    // slot walk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state    <= qows_pkg::WRR_LOOK;
            cur_slot <= 4'h0;
            served   <= 4'h0;
            cnt_l    <= 4'h0;
            tx_sel   <= '0;
        end else begin
            unique case (state)
                qows_pkg::WRR_LOOK: begin
                    state <= qows_pkg::WRR_CHECK;
                end
                qows_pkg::WRR_CHECK: begin
                    if (slot_byte[qows_pkg::CNT_LSB +: qows_pkg::FIELD_W]
                            != 4'h0 &&
                        tx_queue_pending[slot_byte[qows_pkg::PTR_LSB +:
                            qows_pkg::FIELD_W]]) begin
                        state        <= qows_pkg::WRR_SERVE;
                        served       <= 4'h0;
                        cnt_l        <= slot_byte[qows_pkg::CNT_LSB +:
                                                  qows_pkg::FIELD_W];
                        tx_sel.valid <= 1'b1;
                        tx_sel.queue <= slot_byte[qows_pkg::PTR_LSB +:
                                                  qows_pkg::FIELD_W];
                    end else begin
                        state    <= qows_pkg::WRR_LOOK;
                        cur_slot <= cur_slot + 4'h1;
                    end
                end
                qows_pkg::WRR_SERVE: begin
                    if (tx_msg_done && (served + 4'h1) != cnt_l) begin
                        served <= served + 4'h1;
                    end else if (tx_msg_done ||
                                 !tx_queue_pending[tx_sel.queue]) begin
                        state        <= qows_pkg::WRR_LOOK;
                        cur_slot     <= cur_slot + 4'h1;
                        tx_sel.valid <= 1'b0;
                    end
                end
                default: begin
                    state <= qows_pkg::WRR_LOOK;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= 16'h0000;
        end else begin
            pend_q <= tx_queue_pending;
        end
    end

    //------------------------------------------------------------------
    // checks
    //------------------------------------------------------------------
    property p_order_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_fire && hit_order) |=> rx_in_order == $past(pwdata[15:0]);
    endproperty
    a_order_write: assert property (p_order_write)
        else $error("ordering bits not updated by write");

    property p_order_reserved;
        @(posedge pclk) disable iff (!presetn)
        (psel && pready && !pwrite && hit_order) |->
            prdata[31:16] == 16'h0000 && prdata[15:0] == rx_order;
    endproperty
    a_order_reserved: assert property (p_order_reserved)
        else $error("ordering register read wrong");

    property p_pick;
        @(posedge pclk) disable iff (!presetn)
        $rose(tx_sel.valid) |->
            pend_q[tx_sel.queue] && tx_sel.queue == $past(slot_byte[3:0]);
    endproperty
    a_pick: assert property (p_pick)
        else $error("selected queue not from slot or idle");

    property p_count_bound;
        @(posedge pclk) disable iff (!presetn)
        state == qows_pkg::WRR_SERVE |-> served < cnt_l && tx_sel.valid;
    endproperty
    a_count_bound: assert property (p_count_bound)
        else $error("served more than slot count");

    property p_advance;
        @(posedge pclk) disable iff (!presetn)
        (state == qows_pkg::WRR_SERVE && tx_msg_done &&
         (served + 4'h1) == cnt_l) |=>
            !tx_sel.valid && cur_slot == $past(cur_slot) + 4'h1;
    endproperty
    a_advance: assert property (p_advance)
        else $error("slot did not advance after count");

    property p_answer;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable) ##1 (psel && penable) |=> pready;
    endproperty
    a_answer: assert property (p_answer)
        else $error("apb answer not after one wait state");

    c_serve: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(tx_sel.valid));
    c_wrap: cover property (@(posedge pclk) disable iff (!presetn)
        cur_slot == 4'hF ##1 cur_slot == 4'h0);
    c_err: cover property (@(posedge pclk) disable iff (!presetn)
        pready && pslverr);
endmodule

/* File: tb_qows_top.sv */
`timescale 1ns/10ps
module tb_qows_top;
    //------------------------------------------------------------------
    // stimulus and bench state
    //------------------------------------------------------------------
    logic                       pclk = 1'b0;
    logic                       presetn = 1'b0;
    logic                       psel = 1'b0;
    logic                       penable = 1'b0;
    logic                       pwrite = 1'b0;
    logic [11:0]                paddr = 12'h000;
    logic [31:0]                pwdata = 32'h0;
    logic [31:0]                prdata;
    logic                       pready;
    logic                       pslverr;
    logic [15:0]                tx_queue_pending = 16'h0000;
    logic                       tx_msg_done = 1'b0;
    qows_pkg::qows_tx_sel_t     tx_sel;
    qows_pkg::qows_rx_msg_t     rx_msg = '0;
    qows_pkg::qows_rx_verdict_t rx_verdict;
    logic [15:0]                rx_in_order;
    int                         errors = 0;
    int                         comparisons = 0;
    int                         cycles = 0;
    integer                     seed = 33215;
    logic [3:0]                 cnt [16];

    always #5 pclk = ~pclk;

    qows_top u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .tx_queue_pending(tx_queue_pending), .tx_msg_done(tx_msg_done),
        .tx_sel(tx_sel), .rx_msg(rx_msg), .rx_verdict(rx_verdict),
        .rx_in_order(rx_in_order)
    );

    //------------------------------------------------------------------
    // helpers
    //------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("comparisons %0d, errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // a hang in any wait ends here instead of running forever
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            end_sim();
        end
    end

    // one apb transfer; waits for pready, then checks data and error
    task automatic acc(input logic wr, input logic [11:0] addr,
                       input logic [31:0] wd, input logic [31:0] exp,
                       input logic exp_err);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        check(prdata, exp);
        check({31'h0, pslverr}, {31'h0, exp_err});
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [3:0] ptr(int k, logic perm);
        return perm ? 4'(k * 7 + 3) : 4'(k);
    endfunction

    function automatic logic [31:0] slot_word(int i, logic perm);
        logic [31:0] w;
        for (int b = 0; b < 4; b++) begin
            w[8*b +: 8] = {cnt[4*i+b], ptr(4*i+b, perm)};
        end
        return w;
    endfunction

    //------------------------------------------------------------------
    // main sequence
    //------------------------------------------------------------------
    initial begin
        logic [31:0] w;
        logic [15:0] ord;
        logic [3:0]  q;
        int          s;
        int          n;
        for (int k = 0; k < 16; k++) cnt[k] = 4'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;

        acc(1'b0, qows_pkg::RX_ORDER_OFF, 32'h0, 32'h0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            w = slot_word(i, 1'b0);
            acc(1'b0, qows_pkg::SLOTS_0_3_OFF + 12'(4*i), 32'h0, w,
                1'b0);
        end
        $display("test reset values done");

        acc(1'b0, 12'h000, 32'h0, 32'h0, 1'b1);
        acc(1'b1, 12'h746, 32'hFFFFFFFF, 32'h0, 1'b1);
        acc(1'b0, qows_pkg::RX_ORDER_OFF, 32'h0, 32'h0, 1'b0);
        for (int k = 0; k < 3; k++) begin
            w = $random(seed);
            ord = w[15:0];
            acc(1'b1, qows_pkg::RX_ORDER_OFF, w, 32'h0, 1'b0);
            acc(1'b0, qows_pkg::RX_ORDER_OFF, 32'h0, {16'h0, ord}, 1'b0);
            check({16'h0, rx_in_order}, {16'h0, ord});
        end
        $display("test ordering register done");

        for (int k = 0; k < 40; k++) begin
            w = $random(seed);
            @(posedge pclk);
            rx_msg <= {1'b1, w[3:0], w[4]};
            @(posedge pclk);
            rx_msg.valid <= 1'b0;
            @(negedge pclk);
            q = w[3:0];
            check(32'(rx_verdict),
                  32'({~ord[q] | w[4], ord[q] & ~w[4], q}));
        end
        $display("test receive ordering done");

        for (int k = 0; k < 16; k++) cnt[k] = 4'($random(seed));
        cnt[0]  = 4'h1;
        cnt[5]  = 4'h0;
        cnt[15] = 4'hF;
        for (int i = 0; i < 4; i++) begin
            w = slot_word(i, 1'b1);
            acc(1'b1, qows_pkg::SLOTS_0_3_OFF + 12'(4*i), w, 32'h0, 1'b0);
            acc(1'b0, qows_pkg::SLOTS_0_3_OFF + 12'(4*i), 32'h0, w,
                1'b0);
        end
        @(posedge pclk);
        tx_queue_pending <= 16'hFFFF;
        s = -1;
        for (int e = 0; e < 24; e++) begin
            n = 0;
            while (tx_sel.valid !== 1'b1 && n < 100) begin
                @(negedge pclk);
                n++;
            end
            q = tx_sel.queue;
            if (s < 0) begin
                for (int k = 0; k < 16; k++) if (ptr(k, 1'b1) == q) s = k;
            end else begin
                // skip zero counts, wrap after fifteen
                do s = (s + 1) % 16; while (cnt[s] == 4'h0);
                check({28'h0, q}, {28'h0, ptr(s, 1'b1)});
            end
            n = 0;
            while (tx_sel.valid === 1'b1 && n < 60) begin
                if (tx_msg_done === 1'b1) n++;
                @(posedge pclk);
                tx_msg_done <= 1'($random(seed));
                @(negedge pclk);
            end
            @(posedge pclk);
            tx_msg_done <= 1'b0;
            check(32'(n), {28'h0, cnt[s]});
        end
        $display("test round robin done");
        end_sim();
    end
endmodule
